// ---- rtl/dcf_pkg.sv ----
package dcf_pkg;

    // word and offset widths
    localparam int DCF_DATA_W = 18;
    localparam int DCF_OFF_W = 12;

    // storage depth of the smallest variant; 512, 1024 and 4096 also valid
    localparam int DCF_DEPTH = 256;

    // staging buffer between the write pins and the storage array
    localparam int DCF_STAGE_DEPTH = 8;

    // width used for count versus offset comparisons (covers 4096 words)
    localparam int DCF_CMP_W = 16;

    // depth of every pin synchroniser, in flip-flops
    localparam int DCF_SYNC_STAGES = 2;

    // default almost distances, per storage depth
    localparam logic [11:0] DCF_OFF_DEF_256 = 12'h01f;
    localparam logic [11:0] DCF_OFF_DEF_512 = 12'h03f;
    localparam logic [11:0] DCF_OFF_DEF_LARGE = 12'h07f;

    // position of the alternating offset pointer
    localparam logic DCF_SEL_EMPTY = 1'b0;
    localparam logic DCF_SEL_FULL = 1'b1;

    // default offset chosen from the storage depth
    function automatic logic [11:0] dcf_default_offset(input int depth);
        logic [11:0] value;
        value = DCF_OFF_DEF_LARGE;
        if (depth == 256) begin
            value = DCF_OFF_DEF_256;
        end else if (depth == 512) begin
            value = DCF_OFF_DEF_512;
        end
        return value;
    endfunction

endpackage

// ---- rtl/dcf_fifo.sv ----
`timescale 1ns/1ps

// small staging buffer with valid and ready on both sides
module dcf_stage_fifo
    import dcf_pkg::*;
#(
    parameter int WIDTH = DCF_DATA_W,
    parameter int DEPTH = DCF_STAGE_DEPTH,
    parameter int AW = $clog2(DEPTH),
    parameter int LW = $clog2(DEPTH) + 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [LW-1:0] level
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic take;
    logic give;

    // honest full and empty from the word count
    assign in_ready = (level != LW'(DEPTH));
    assign out_valid = (level != '0);
    assign out_data = mem[rp];
    assign take = in_valid & in_ready;
    assign give = out_valid & out_ready;

    // storage
    always_ff @(posedge clk) begin
        if (take) begin
            mem[wp] <= in_data;
        end
    end

    // pointers and count, wrapping at the end of the buffer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wp <= '0;
            rp <= '0;
            level <= '0;
        end else if (clear) begin
            wp <= '0;
            rp <= '0;
            level <= '0;
        end else begin
            if (take) begin
                wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
            end
            if (give) begin
                rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
            end
            level <= level + LW'(take) - LW'(give);
        end
    end
endmodule

// Function
// R01: storage array of DEPTH words, 18 bits each, separate read and write pointers
// R02: reset needed before first access; reset empties buffer, empty flag low
// R03: with output enable asserted, data outputs go low after reset falls
// R04: outside agents do not read or write while reset is low
// R05: write enable low, load high: capture input word on each write clock rise
// R06: read enable and output enable low: next word shown each read clock rise
// R07: output enable high floats outputs; low drives the output register
// R08: writes ignored when full, reads ignored when empty, pointers unchanged
// R09: empty buffer keeps last valid read word on outputs
// R10: two 12-bit offset registers loaded from input bits 0 to 11
// R11: load and write enable low: empty offset, then full offset, alternating
// R12: offset sequence position kept across load high; next load continues it
// R13: load and read enable low: offsets read out in same alternating order
// R14: load selects offset or buffer write; write enable high is no operation
// R15: full flag low at full depth, updated on write clock rises only
// R16: empty flag low at zero words, updated on read clock rises only; code also updates it on retransmit
// R17: almost empty low at count up to offset; almost full from depth minus offset
// R18: half-full flag low when count exceeds half the depth
// R19: sync mode low: almost flags follow their own clock; high: asynchronous
// R20: default offsets 31, 63 or 127 depending on depth
// R21: retransmit pulse returns read pointer to location zero, standalone only
// R22: outside agents hold clocks still around retransmit, writes not above depth
// R23: after retransmit reads replay old data; flags recomputed from pointers
// R24: write expansion out pin carries the half-full flag
// R25: board ties first load and expansion inputs low when not cascaded
// R26: pointers wrap to zero; count kept safely despite foreign pin clocks
module dcf_fifo
    import dcf_pkg::*;
#(
    parameter int DATA_W = DCF_DATA_W,
    parameter int DEPTH = DCF_DEPTH,
    parameter int STAGE_DEPTH = DCF_STAGE_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic write_clk,
    input wire logic read_clk,
    input wire logic write_en_n,
    input wire logic read_en_n,
    input wire logic offset_load_n,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic output_enable_n,
    input wire logic retransmit,
    input wire logic sync_flag_mode_n,
    input wire logic first_device_n,
    input wire logic write_expand_in,
    input wire logic read_expand_in,
    input wire logic reset_n,
    output logic [DATA_W-1:0] data_out,
    output logic data_out_oe,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_n,
    output logic almost_full_n,
    output logic half_full_n,
    output logic write_expand_out,
    output logic read_expand_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam int LW = $clog2(STAGE_DEPTH) + 1;
    localparam int PIN_W = 12 + DATA_W;
    localparam logic [DCF_OFF_W-1:0] OFF_DEF = dcf_default_offset(DEPTH);

    // pin synchroniser chain and its outputs
    logic [PIN_W-1:0] pin_sync [DCF_SYNC_STAGES];
    logic [PIN_W-1:0] pin_q;
    logic wclk_s, rclk_s, wen_n_s, ren_n_s, ld_n_s, oe_n_s, rt_s;
    logic sync_flag_mode_n_n_s, fl_n_s, wxi_s, rxi_s, rst_n_s;
    logic [DATA_W-1:0] din_s;
    logic [2:0] edge_prev;
    logic wr_edge, rd_edge, rt_edge, clr;

    // storage and pointers
    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic wrapped;
    logic [CW-1:0] fill;
    logic [CW-1:0] next_fill;
    logic [CW-1:0] total;
    logic [CW-1:0] next_total;
    logic [LW-1:0] next_level;
    logic [DATA_W-1:0] rd_word;

    // offsets
    logic [DCF_OFF_W-1:0] empty_off;
    logic [DCF_OFF_W-1:0] full_off;
    logic wr_sel;
    logic rd_sel;
    logic [DCF_OFF_W-1:0] rd_off;

    // operations
    logic prog_wr, prog_rd, push, pop, drain, rt_go;
    logic stage_in_ready, stage_out_valid;
    logic [DATA_W-1:0] stage_data;
    logic [LW-1:0] stage_level;
    logic [DCF_CMP_W-1:0] cmp_total;
    logic [DCF_CMP_W-1:0] full_limit;

    // every pin input passes two flip-flops before use
    assign pin_q = pin_sync[DCF_SYNC_STAGES-1];
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < DCF_SYNC_STAGES; i++) begin
                pin_sync[i] <= '0;
            end
        end else begin
            pin_sync[0] <= {write_clk, read_clk, write_en_n, read_en_n, offset_load_n,
                            output_enable_n, retransmit, sync_flag_mode_n, first_device_n,
                            write_expand_in, read_expand_in, reset_n, data_in};
            for (int i = 1; i < DCF_SYNC_STAGES; i++) begin
                pin_sync[i] <= pin_sync[i-1];
            end
        end
    end

    assign {wclk_s, rclk_s, wen_n_s, ren_n_s, ld_n_s, oe_n_s, rt_s, sync_flag_mode_n_n_s, fl_n_s,
            wxi_s, rxi_s, rst_n_s, din_s} = pin_q;

    // rising edges of the pin clocks and the retransmit strobe become enables
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            edge_prev <= '0;
        end else begin
            edge_prev <= {wclk_s, rclk_s, rt_s};
        end
    end

    assign wr_edge = wclk_s & ~edge_prev[2];
    assign rd_edge = rclk_s & ~edge_prev[1];
    assign rt_edge = rt_s & ~edge_prev[0];
    assign clr = ~rst_n_s;                                  // see R02

    // operation decode from load and the two enables
    assign prog_wr = wr_edge & ~wen_n_s & ~ld_n_s & ~clr;   // see R14
    assign push = wr_edge & ~wen_n_s & ld_n_s & full_flag_n & stage_in_ready
                  & (total != CW'(DEPTH)) & ~clr;           // see R05 see R08
    assign prog_rd = rd_edge & ~ren_n_s & ~ld_n_s & ~clr;   // see R13
    assign rt_go = rt_edge & fl_n_s == 1'b0 & ~wxi_s & ~rxi_s & ~clr;  // see R21
    assign pop = rd_edge & ~ren_n_s & ld_n_s & ~oe_n_s & empty_flag_n
                 & (fill != '0) & ~rt_go & ~clr;            // see R06 see R08 see R16
    assign drain = stage_out_valid & (fill != CW'(DEPTH)) & ~rt_go & ~clr;

    // staging buffer between write pins and array; when it fills, writes are dropped
    dcf_stage_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(STAGE_DEPTH)
    ) u_stage (
        .clk(clk),
        .reset(reset),
        .clear(clr),
        .in_valid(push),
        .in_ready(stage_in_ready),
        .in_data(din_s),
        .out_valid(stage_out_valid),
        .out_ready(drain),
        .out_data(stage_data),
        .level(stage_level)
    );

    // storage array write
    always_ff @(posedge clk) begin
        if (drain) begin
            mem[wptr] <= stage_data;                        // see R01
        end
    end

    assign rd_word = mem[rptr];

    // write pointer wraps after the last location
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wptr <= '0;
            wrapped <= 1'b0;
        end else if (clr) begin
            wptr <= '0;
            wrapped <= 1'b0;
        end else if (drain) begin
            wptr <= wptr + AW'(1);                          // see R26
            if (wptr == AW'(DEPTH - 1)) begin
                wrapped <= 1'b1;
            end
        end
    end

    // read pointer: advance on read, back to zero on retransmit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rptr <= '0;
        end else if (clr || rt_go) begin
            rptr <= '0;                                     // see R21
        end else if (pop) begin
            rptr <= rptr + AW'(1);                          // see R26 see R23
        end
    end

    // word counts; retransmit rebuilds the count from the write pointer
    always_comb begin
        next_level = stage_level + LW'(push) - LW'(drain);
        if (rt_go) begin
            next_fill = wrapped ? CW'(DEPTH) : CW'(wptr);   // see R23
        end else begin
            next_fill = fill + CW'(drain) - CW'(pop);
        end
        next_total = next_fill + CW'(next_level);
    end

    assign total = fill + CW'(stage_level);
    assign cmp_total = DCF_CMP_W'(next_total);
    assign full_limit = DCF_CMP_W'(DEPTH) - DCF_CMP_W'(full_off);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fill <= '0;
        end else if (clr) begin
            fill <= '0;
        end else begin
            fill <= next_fill;
        end
    end

    // offset registers, written alternately empty then full
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            empty_off <= OFF_DEF;                           // see R20
            full_off <= OFF_DEF;
            wr_sel <= DCF_SEL_EMPTY;
        end else if (clr) begin
            empty_off <= OFF_DEF;
            full_off <= OFF_DEF;
            wr_sel <= DCF_SEL_EMPTY;
        end else if (prog_wr) begin
            if (wr_sel == DCF_SEL_EMPTY) begin
                empty_off <= din_s[DCF_OFF_W-1:0];          // see R10 see R11
            end else begin
                full_off <= din_s[DCF_OFF_W-1:0];
            end
            wr_sel <= ~wr_sel;                              // see R12
        end
    end

    // offset read pointer, same alternating order
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_sel <= DCF_SEL_EMPTY;
        end else if (clr) begin
            rd_sel <= DCF_SEL_EMPTY;
        end else if (prog_rd) begin
            rd_sel <= ~rd_sel;                              // see R13
        end
    end

    assign rd_off = (rd_sel == DCF_SEL_EMPTY) ? empty_off : full_off;

    // output register: holds last valid word while empty
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_out <= '0;
        end else if (clr) begin
            data_out <= '0;                                 // see R03
        end else if (pop) begin
            data_out <= rd_word;                            // see R06 see R09
        end else if (prog_rd) begin
            data_out <= {{(DATA_W - DCF_OFF_W){1'b0}}, rd_off};
        end
    end

    // output drive follows the output enable pin
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_out_oe <= 1'b0;
        end else begin
            data_out_oe <= ~oe_n_s;                         // see R07 see R03
        end
    end

    // boundary flags: full updated on write clock rises only, empty on read clock rises or retransmit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            empty_flag_n <= 1'b0;
            full_flag_n <= 1'b1;
        end else if (clr) begin
            empty_flag_n <= 1'b0;                           // see R02
            full_flag_n <= 1'b1;
        end else begin
            if (rd_edge || rt_go) begin
                empty_flag_n <= (next_fill != '0);          // see R16 see R23
            end
            if (wr_edge) begin
                full_flag_n <= (next_total != CW'(DEPTH));  // see R15
            end
        end
    end

    // almost flags, synchronous to their clock or following the count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            almost_empty_n <= 1'b0;
            almost_full_n <= 1'b1;
        end else if (clr) begin
            almost_empty_n <= 1'b0;
            almost_full_n <= 1'b1;
        end else begin
            if (sync_flag_mode_n_n_s || rd_edge || rt_go) begin        // see R19
                almost_empty_n <= (cmp_total > DCF_CMP_W'(empty_off));  // see R17
            end
            if (sync_flag_mode_n_n_s || wr_edge) begin                 // see R19
                almost_full_n <= (cmp_total < full_limit);  // see R17
            end
        end
    end

    // half-full flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            half_full_n <= 1'b1;
        end else if (clr) begin
            half_full_n <= 1'b1;
        end else begin
            half_full_n <= (total <= CW'(DEPTH / 2));       // see R18
        end
    end

    // standalone use: expansion out carries half full, read expansion idle
    assign write_expand_out = half_full_n;                  // see R24
    assign read_expand_out = 1'b1;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    sequence s_prog_write;
        prog_wr;
    endsequence

    // first read after a retransmit, while the read pointer still sits at zero
    sequence s_retx_then_read;
        rt_go ##[1:40] (pop && rptr == AW'(0));
    endsequence

    a_reset_empty: assert property (clr |=> !empty_flag_n && data_out == '0) // see R02
        else $error("pin reset did not empty the buffer");
    a_write_count: assert property ((push && !pop && !rt_go) |=> total == $past(total) + 1) // see R05
        else $error("accepted write did not raise the count");
    a_read_word: assert property (pop |=> data_out == $past(rd_word)) // see R06
        else $error("read did not present the stored word");
    a_full_block: assert property ((!full_flag_n && !pop && !rt_go && !clr) // see R08
        |=> total == $past(total))
        else $error("write accepted while full flag low");
    a_empty_hold: assert property ((fill == '0 && !rt_go && !prog_rd && !clr) |=> $stable(data_out)) // see R09
        else $error("output changed while empty");
    a_offset_alt: assert property (s_prog_write |=> wr_sel != $past(wr_sel)) // see R11
        else $error("offset write did not advance the sequence");
    a_offset_read: assert property (prog_rd |=> data_out[DCF_OFF_W-1:0] == $past(rd_off)) // see R13
        else $error("offset read returned wrong value");
    a_full_stable: assert property ((!wr_edge && !clr) |=> $stable(full_flag_n)) // see R15
        else $error("full flag moved without a write clock edge");
    a_empty_stable: assert property ((!rd_edge && !rt_go && !clr) |=> $stable(empty_flag_n)) // see R16
        else $error("empty flag moved without a read clock edge");
    a_half_full: assert property (!clr |=> half_full_n == ($past(total) <= CW'(DEPTH / 2))) // see R18
        else $error("half full flag wrong");
    a_af_sync: assert property ((!sync_flag_mode_n_n_s && !wr_edge && !clr) |=> $stable(almost_full_n)) // see R19
        else $error("almost full moved off its clock");
    a_retx_replay: assert property (s_retx_then_read |=> data_out == mem[0] && rptr == AW'(1)) // see R21
        else $error("retransmit did not replay from location zero");
    a_retx_flag: assert property (rt_go |=> empty_flag_n == (fill != '0)) // see R23
        else $error("empty flag not recomputed on retransmit");
endmodule

// ---- testbench/dcf_pin_host.sv ----
`timescale 1ns/1ps

// host logic beyond the pins: writer and reader agents driving the pin strobes
module dcf_pin_host
    import dcf_pkg::*;
(
    input wire logic clk,
    output logic write_clk,
    output logic read_clk,
    output logic write_en_n,
    output logic read_en_n,
    output logic offset_load_n,
    output logic [DCF_DATA_W-1:0] data_in,
    output logic output_enable_n,
    output logic retransmit
);
    // clk cycles each pin clock level lasts; raise it for a slow host
    int phase = 4;

    // idle levels: strobes inactive, pin clocks still
    initial begin
        write_clk = 1'b0;
        read_clk = 1'b0;
        write_en_n = 1'b1;
        read_en_n = 1'b1;
        offset_load_n = 1'b1;
        data_in = 18'h15555;
        output_enable_n = 1'b0;
        retransmit = 1'b0;
    end

    // one pin clock pulse, levels held past the synchroniser, then strobes dropped
    task automatic strobe(input logic is_write);
        @(posedge clk);
        #1;
        if (is_write) begin
            write_clk = 1'b1;
        end else begin
            read_clk = 1'b1;
        end
        repeat (phase) @(posedge clk);
        #1;
        write_clk = 1'b0;
        read_clk = 1'b0;
        repeat (phase) @(posedge clk);
        #1;
        write_en_n = 1'b1;
        read_en_n = 1'b1;
        offset_load_n = 1'b1;
    endtask

    // write cycle; the data lines show the inverse once released
    task automatic write_word(input logic [DCF_DATA_W-1:0] d, input logic load_n,
                              input logic en_n);
        @(posedge clk);
        #1;
        write_en_n = en_n;
        offset_load_n = load_n;
        data_in = d;
        strobe(1'b1);
        data_in = ~d;
    endtask

    // read cycle, buffer or offset register by load level
    task automatic read_word(input logic load_n);
        @(posedge clk);
        #1;
        read_en_n = 1'b0;
        offset_load_n = load_n;
        strobe(1'b0);
    endtask

    task automatic set_oe(input logic oe_n);
        @(posedge clk);
        #1;
        output_enable_n = oe_n;
    endtask

    // pin clocks stand still during the pulse and the recovery after it
    task automatic pulse_retransmit();
        @(posedge clk);
        #1;
        retransmit = 1'b1;
        repeat (phase) @(posedge clk);
        #1;
        retransmit = 1'b0;
        repeat (phase) @(posedge clk);
        #1;
    endtask
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/1ps

// self-checking bench driving the pins through the host model
module tb
    import dcf_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reset_n = 1'b0;
    logic write_clk, read_clk, write_en_n, read_en_n, offset_load_n;
    logic output_enable_n, retransmit;
    logic [DCF_DATA_W-1:0] data_in, data_out;
    logic data_out_oe, empty_flag_n, full_flag_n, almost_empty_n, almost_full_n;
    logic half_full_n, write_expand_out, read_expand_out;
    logic [6:0] flg;
    logic sync_flag_mode_n = 1'b0;
    logic first_device_n = 1'b0;
    logic write_expand_in = 1'b0;
    logic read_expand_in = 1'b0;
    int miscompares = 0;
    int total_checks = 0;
    int cnt;

    always #20 clk = ~clk;

    // flag bundle: expansion outs, empty, full, almost empty, almost full, half
    assign flg = {read_expand_out, write_expand_out, empty_flag_n, full_flag_n,
                  almost_empty_n, almost_full_n, half_full_n};

    dcf_pin_host u_host (.clk(clk), .write_clk(write_clk), .read_clk(read_clk),
        .write_en_n(write_en_n), .read_en_n(read_en_n), .offset_load_n(offset_load_n),
        .data_in(data_in), .output_enable_n(output_enable_n), .retransmit(retransmit));

    // standalone use by default: no cascade, synchronous almost flags
    dcf_fifo #(.DEPTH(DCF_DEPTH)) u_dut (.clk(clk), .reset(reset), .write_clk(write_clk),
        .read_clk(read_clk), .write_en_n(write_en_n), .read_en_n(read_en_n),
        .offset_load_n(offset_load_n), .data_in(data_in), .output_enable_n(output_enable_n),
        .retransmit(retransmit), .sync_flag_mode_n(sync_flag_mode_n),
        .first_device_n(first_device_n), .write_expand_in(write_expand_in),
        .read_expand_in(read_expand_in), .reset_n(reset_n),
        .data_out(data_out), .data_out_oe(data_out_oe), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .almost_empty_n(almost_empty_n),
        .almost_full_n(almost_full_n), .half_full_n(half_full_n),
        .write_expand_out(write_expand_out), .read_expand_out(read_expand_out));

    function automatic logic [17:0] pat(input int i);
        return {2'b10, i[7:0], ~i[7:0]};
    endfunction

    // expected bundle; the half flag is mirrored on the expansion out
    function automatic logic [6:0] xf(input logic e, f, ae, af, hf);
        return {1'b1, hf, e, f, ae, af, hf};
    endfunction

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkf(input logic [6:0] exp);
        chk({11'h0, flg}, {11'h0, exp});
    endtask

    task automatic end_test(input string name);
        $display("test %s done", name);
    endtask

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chkf(xf(0, 1, 0, 1, 1));
        chk(data_out, 18'h0);
        chk({17'h0, data_out_oe}, 18'h1);
        end_test("reset");
        // offsets: defaults, alternation, sequence kept across load high
        u_host.write_word(18'h00005, 1'b0, 1'b1);
        u_host.read_word(1'b0);
        chk(data_out, 18'h0001f);
        u_host.read_word(1'b0);
        chk(data_out, 18'h0001f);
        u_host.write_word(18'h3f005, 1'b0, 1'b0);
        u_host.write_word(18'h3f00a, 1'b0, 1'b0);
        u_host.write_word(18'h00000, 1'b1, 1'b1);
        u_host.write_word(18'h2a007, 1'b0, 1'b0);
        u_host.read_word(1'b0);
        chk(data_out, 18'h00007);
        u_host.read_word(1'b0);
        chk(data_out, 18'h0000a);
        chkf(xf(0, 1, 0, 1, 1));
        end_test("offsets");
        // fill to full: no read edges, so empty and almost empty stay put
        for (int i = 0; i < DCF_DEPTH; i++) begin
            u_host.write_word(pat(i), 1'b1, 1'b0);
            cnt = i + 1;
            chkf(xf(0, cnt != DCF_DEPTH, 0, cnt < DCF_DEPTH - 10, cnt <= DCF_DEPTH / 2));
        end
        u_host.write_word(18'h3ffff, 1'b1, 1'b0);
        chkf(xf(0, 0, 0, 0, 0));
        end_test("fill");
        // first read edge only lifts the empty and almost empty flags
        u_host.read_word(1'b1);
        chkf(xf(1, 0, 1, 0, 0));
        chk(data_out, 18'h0000a);
        u_host.set_oe(1'b1);
        u_host.read_word(1'b1);
        chk({17'h0, data_out_oe}, 18'h0);
        chk(data_out, 18'h0000a);
        u_host.set_oe(1'b0);
        for (int i = 0; i < DCF_DEPTH; i++) begin
            u_host.read_word(1'b1);
            cnt = DCF_DEPTH - 1 - i;
            chk(data_out, pat(i));
            chkf(xf(cnt != 0, 0, cnt > 7, 0, cnt <= DCF_DEPTH / 2));
        end
        u_host.read_word(1'b1);
        chk(data_out, pat(DCF_DEPTH - 1));
        // free-running almost flags follow the count without a write edge
        sync_flag_mode_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        chkf(xf(0, 0, 0, 1, 1));
        sync_flag_mode_n = 1'b0;
        end_test("drain");
        // replay with a slow host
        u_host.phase = 7;
        u_host.pulse_retransmit();
        chk({17'h0, empty_flag_n}, 18'h1);
        for (int i = 0; i < 3; i++) begin
            u_host.read_word(1'b1);
            chk(data_out, pat(i));
        end
        u_host.phase = 4;
        // retransmit refused unless standalone; reading simply carries on
        first_device_n = 1'b1;
        u_host.pulse_retransmit();
        first_device_n = 1'b0;
        write_expand_in = 1'b1;
        read_expand_in = 1'b1;
        u_host.pulse_retransmit();
        write_expand_in = 1'b0;
        read_expand_in = 1'b0;
        u_host.read_word(1'b1);
        chk(data_out, pat(3));
        end_test("retransmit");
        // pin reset in mid-run restores the defaults
        @(posedge clk);
        #1;
        reset_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chkf(xf(0, 1, 0, 1, 1));
        chk(data_out, 18'h0);
        reset_n = 1'b1;
        repeat (4) @(posedge clk);
        u_host.read_word(1'b0);
        chk(data_out, 18'h0001f);
        end_test("pin reset");
        report_and_stop();
    end
endmodule
